// >>> dbp_pkg.sv
// Package for the dual bidirectional port block: widths, reset values, carriers.
// Assumes a single 50 MHz clock domain and synchronous active-low reset.
package dbp_pkg;

  // ==========================================================================
  // Widths and reset values
  localparam int          DBP_W         = 8;
  localparam logic [7:0]  DBP_DIR_RST   = 8'hff;
  localparam logic [7:0]  DBP_LAT_RST   = 8'h00;
  localparam logic [7:0]  DBP_E_RST     = 8'h07;
  localparam int          DBP_SEL_BIT   = 4;
  localparam int          DBP_PWM_A_BIT = 4;
  localparam int          DBP_PWM_B_BIT = 5;
  localparam int          DBP_PWM_C_BIT = 6;
  localparam int          DBP_PWM_D_BIT = 7;

  // ==========================================================================
  // Enhanced PWM output modes
  typedef enum logic [1:0] {
    DBP_PWM_SINGLE = 2'b00,
    DBP_PWM_HALF   = 2'b01,
    DBP_PWM_FULL_F = 2'b10,
    DBP_PWM_FULL_R = 2'b11
  } dbp_pwm_mode_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       dir_we;
    logic       lat_we;
    logic       port_we;
    logic [7:0] wdata;
  } dbp_wr_t;

  typedef struct packed {
    logic [7:0] ovr_en;
    logic [7:0] ovr_out;
    logic [7:0] ovr_val;
  } dbp_ovr_t;

  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
  } dbp_pad_t;

endpackage

// >>> dbp_bank.sv
// One 8-bit bidirectional bank: direction, output latch, synchronised pin read.
// Assumes pin inputs are synchronous to clk; overrides come from peripherals.
module dbp_bank
  import dbp_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Software side
  input  wire dbp_pkg::dbp_wr_t  wr,
  output logic [7:0]           dir_q,
  output logic [7:0]           lat_q,
  output logic [7:0]           pin_q,
  // Peripheral override
  input  wire dbp_pkg::dbp_ovr_t ovr,
  // Pins
  input  wire logic [7:0]      pin_in,
  output dbp_pkg::dbp_pad_t    pad_q
);
  import dbp_pkg::*;

  logic [7:0] dir_d, lat_d, pin_d;
  wire  [7:0] oe_n_d;
  wire  [7:0] out_d;
  dbp_pad_t   pad_d;

  // ==========================================================================
  // Register next state
  always_comb begin
    dir_d = dir_q;
    lat_d = lat_q;
    pin_d = pin_in;
    if (wr.dir_we) begin
      dir_d = wr.wdata;
    end
    if (wr.lat_we || wr.port_we) begin
      lat_d = wr.wdata;
    end
    if (!rst_n) begin
      dir_d = DBP_DIR_RST;
      lat_d = DBP_LAT_RST;
      pin_d = DBP_LAT_RST;
    end
  end

  // ==========================================================================
  // Per-bit effective direction and drive
  // Each bit has its own driver, so no two processes share one variable
  for (genvar i = 0; i < DBP_W; i++) begin : g_bit
    assign oe_n_d[i] = !rst_n        ? 1'b1 :
                       ovr.ovr_en[i] ? !ovr.ovr_out[i] :
                                       dir_d[i];
    assign out_d[i]  = !rst_n        ? 1'b0 :
                       ovr.ovr_en[i] ? ovr.ovr_val[i] :
                                       lat_d[i];
  end

  always_comb begin
    pad_d.pin_oe_n = oe_n_d;
    pad_d.pin_out  = out_d;
  end

  always_ff @(posedge clk) begin
    dir_q <= dir_d;
    lat_q <= lat_d;
    pin_q <= pin_d;
    pad_q <= pad_d;
  end

endmodule // dbp_bank

// >>> dbp_top.sv
// Top of the dual bidirectional port block: bank C always, bank D by parameter.
// Assumes software strobes are one-cycle pulses synchronous to clk.
//
// Overview of operation
// - Direction one makes pin input, driver off
// - Direction zero drives output latch onto pin
// - Latch register reads back latch, not pins
// - Enabled peripheral may force pin direction
// - Direction read returns stored bits only
// - Reset makes every pin an input
// - Parallel slave select makes bank D data port
// - Dual or quad PWM disables parallel slave
// - PWM outputs take over bank D pins
// - Bank D present only when parameter set
module dbp_top
  import dbp_pkg::*;
#(
  parameter bit HAS_BANK_D = 1'b1
)(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Bank C software side
  input  wire dbp_pkg::dbp_wr_t     wr_c,
  output logic [7:0]                direction_bank_c,
  output logic [7:0]                output_latch_bank_c,
  output logic [7:0]                pin_bank_c_value,
  // Bank C peripheral override
  input  wire dbp_pkg::dbp_ovr_t    ovr_c,
  // Bank C pins
  input  wire logic [7:0]           pin_c_in,
  output dbp_pkg::dbp_pad_t         pad_c,
  // Bank D software side
  input  wire dbp_pkg::dbp_wr_t     wr_d,
  output logic [7:0]                direction_bank_d,
  output logic [7:0]                output_latch_bank_d,
  output logic [7:0]                pin_bank_d_value,
  // Bank D pins
  input  wire logic [7:0]           pin_d_in,
  output dbp_pkg::dbp_pad_t         pad_d,
  // Bank E direction register (holds parallel slave select)
  input  wire logic                 dir_e_we,
  input  wire logic [7:0]           dir_e_wdata,
  output logic [7:0]                direction_bank_e,
  // Parallel slave data port
  input  wire logic                 host_parallel_data_port_drive,
  input  wire logic [7:0]           host_parallel_data_port_out,
  output logic                      host_parallel_data_port_active,
  output logic                      host_parallel_data_port_ttl,
  // Enhanced PWM unit
  input  wire logic                 enhanced_capture_pwm_unit_en,
  input  wire dbp_pkg::dbp_pwm_mode_t pwm_mode,
  input  wire logic                 pwm_output_a,
  input  wire logic                 pwm_output_b,
  input  wire logic                 pwm_output_c,
  input  wire logic                 pwm_output_d
);
  import dbp_pkg::*;

  // ==========================================================================
  // Bank E direction register and parallel slave mode
  logic [7:0] dir_e_d;
  logic       slave_d, slave_q, ttl_d, ttl_q;
  logic       pwm_multi;
  logic [7:0] pwm_used;
  dbp_ovr_t   ovr_d_c;

  always_comb begin
    dir_e_d = direction_bank_e;
    if (dir_e_we) begin
      dir_e_d = dir_e_wdata;
    end
    if (!rst_n) begin
      dir_e_d = DBP_E_RST;
    end
    pwm_multi = enhanced_capture_pwm_unit_en && (pwm_mode != DBP_PWM_SINGLE);
    slave_d = HAS_BANK_D && dir_e_d[DBP_SEL_BIT] && !pwm_multi;
    ttl_d = slave_d;
  end

  always_ff @(posedge clk) begin
    direction_bank_e <= dir_e_d;
    slave_q          <= slave_d;
    ttl_q            <= ttl_d;
  end

  assign host_parallel_data_port_active = slave_q;
  assign host_parallel_data_port_ttl    = ttl_q;

  // ==========================================================================
  // Bank D overrides: parallel slave drive, with PWM pins applied over it
  always_comb begin
    pwm_used = 8'h00;
    if (enhanced_capture_pwm_unit_en) begin
      pwm_used[DBP_PWM_A_BIT] = 1'b1;
      if (pwm_mode != DBP_PWM_SINGLE) begin
        pwm_used[DBP_PWM_B_BIT] = 1'b1;
      end
      if (pwm_mode == DBP_PWM_FULL_F || pwm_mode == DBP_PWM_FULL_R) begin
        pwm_used[DBP_PWM_C_BIT] = 1'b1;
        pwm_used[DBP_PWM_D_BIT] = 1'b1;
      end
    end
    ovr_d_c.ovr_en  = 8'h00;
    ovr_d_c.ovr_out = 8'h00;
    ovr_d_c.ovr_val = 8'h00;
    if (slave_d) begin
      ovr_d_c.ovr_en  = 8'hff;
      ovr_d_c.ovr_out = {8{host_parallel_data_port_drive}};
      ovr_d_c.ovr_val = host_parallel_data_port_out;
    end
    ovr_d_c.ovr_en  = ovr_d_c.ovr_en  | pwm_used;
    ovr_d_c.ovr_out = ovr_d_c.ovr_out | pwm_used;
    ovr_d_c.ovr_val = (ovr_d_c.ovr_val & ~pwm_used)
                    | (pwm_used & {pwm_output_d, pwm_output_c, pwm_output_b,
                                   pwm_output_a, 4'h0});
  end

  // ==========================================================================
  // Bank C
  dbp_bank u_bank_c (
    .clk    (clk),
    .rst_n  (rst_n),
    .wr     (wr_c),
    .dir_q  (direction_bank_c),
    .lat_q  (output_latch_bank_c),
    .pin_q  (pin_bank_c_value),
    .ovr    (ovr_c),
    .pin_in (pin_c_in),
    .pad_q  (pad_c)
  );

  // ==========================================================================
  // Bank D, present only on larger variants
  if (HAS_BANK_D) begin : g_bank_d
    dbp_bank u_bank_d (
      .clk    (clk),
      .rst_n  (rst_n),
      .wr     (wr_d),
      .dir_q  (direction_bank_d),
      .lat_q  (output_latch_bank_d),
      .pin_q  (pin_bank_d_value),
      .ovr    (ovr_d_c),
      .pin_in (pin_d_in),
      .pad_q  (pad_d)
    );
  end else begin : g_no_bank_d
    always_ff @(posedge clk) begin
      direction_bank_d    <= DBP_DIR_RST;
      output_latch_bank_d <= DBP_LAT_RST;
      pin_bank_d_value    <= DBP_LAT_RST;
      pad_d.pin_out       <= DBP_LAT_RST;
      pad_d.pin_oe_n      <= DBP_DIR_RST;
    end
  end

  // ==========================================================================
  // Checks
  reset_inputs_a: assert property (@(posedge clk)
    !rst_n |=> pad_c.pin_oe_n == DBP_DIR_RST && direction_bank_c == DBP_DIR_RST)
    else $error("bank C not input after reset");

  reset_bank_e_a: assert property (@(posedge clk)
    !rst_n |=> direction_bank_e == DBP_E_RST && !host_parallel_data_port_active)
    else $error("bank E not at reset value");

  dir_input_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_c.dir_we && wr_c.wdata[0] && !ovr_c.ovr_en[0]) |=> pad_c.pin_oe_n[0])
    else $error("input bit still driven");

  dir_output_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!direction_bank_c[3] && !ovr_c.ovr_en[3] && !wr_c.dir_we && !wr_c.lat_we
     && !wr_c.port_we) |=> !pad_c.pin_oe_n[3]
     && pad_c.pin_out[3] == $past(output_latch_bank_c[3]))
    else $error("output bit not driving latch");

  latch_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_c.lat_we && !wr_c.dir_we) |=> output_latch_bank_c == $past(wr_c.wdata))
    else $error("latch write lost");

  port_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> pin_bank_c_value == $past(pin_c_in))
    else $error("pin read not sampled");

  ovr_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ovr_c.ovr_en[5] && ovr_c.ovr_out[5]) |=> !pad_c.pin_oe_n[5])
    else $error("override did not force output");

  dir_readback_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ovr_c.ovr_en != 8'h00 && !wr_c.dir_we) |=> $stable(direction_bank_c))
    else $error("direction read changed by override");

  ovr_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ovr_c.ovr_en[2] && !ovr_c.ovr_out[2]) |=> pad_c.pin_oe_n[2])
    else $error("override input ignored");

  slave_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    pwm_multi |=> !host_parallel_data_port_active)
    else $error("parallel slave active with multi PWM");

  slave_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    (HAS_BANK_D && dir_e_we && dir_e_wdata[DBP_SEL_BIT] && !pwm_multi)
    |=> host_parallel_data_port_active && host_parallel_data_port_ttl)
    else $error("parallel slave not entered");

  pwm_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    (HAS_BANK_D && enhanced_capture_pwm_unit_en) |=>
      !pad_d.pin_oe_n[DBP_PWM_A_BIT] && pad_d.pin_out[DBP_PWM_A_BIT] == $past(pwm_output_a))
    else $error("PWM A not on pin");

  pwm_dual_a: assert property (@(posedge clk) disable iff (!rst_n)
    (HAS_BANK_D && enhanced_capture_pwm_unit_en && pwm_mode == DBP_PWM_HALF) |=>
      !pad_d.pin_oe_n[DBP_PWM_B_BIT] && pad_d.pin_out[DBP_PWM_B_BIT] == $past(pwm_output_b))
    else $error("PWM B not on pin");

  pwm_quad_a: assert property (@(posedge clk) disable iff (!rst_n)
    (HAS_BANK_D && enhanced_capture_pwm_unit_en
     && (pwm_mode == DBP_PWM_FULL_F || pwm_mode == DBP_PWM_FULL_R)) |=>
      !pad_d.pin_oe_n[DBP_PWM_D_BIT] && pad_d.pin_out[DBP_PWM_D_BIT] == $past(pwm_output_d))
    else $error("PWM D not on pin");

  bank_d_absent_a: assert property (@(posedge clk)
    !HAS_BANK_D |=> direction_bank_d == DBP_DIR_RST && pad_d.pin_oe_n == DBP_DIR_RST)
    else $error("absent bank D left its reset state");

endmodule // dbp_top

// >>> dbp_pins.sv
// External circuitry on one bank's pins: resolves each pin's level.
// Assumes pad outputs are registered in the block; ext is the outside drive.
module dbp_pins
  import dbp_pkg::*;
(
  // Pad side
  input  wire dbp_pkg::dbp_pad_t pad,
  input  wire logic [7:0]        ext,
  // Resolved pin levels
  output logic [7:0]             pin_in
);
  // ==========================================================================
  // Pin level: block drive where enabled low, otherwise the outside level
  assign pin_in = (pad.pin_oe_n & ext) | (~pad.pin_oe_n & pad.pin_out);
endmodule // dbp_pins

// >>> dbp_tb.sv
// Self-checking bench for the dual port block with a reference model.
// Assumes dbp_pkg and dbp_top are compiled first; one 50 MHz clock.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dbp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dbp_wr_t wr_c, wr_d;
  dbp_ovr_t ovr_c;
  dbp_pad_t pad_c, pad_d;
  dbp_pwm_mode_t mode;
  logic [7:0] pc_in, pd_in, ext_c, ext_d, e_wd, hp_out, dir_c, lat_c, val_c;
  logic [7:0] dir_d, lat_d, val_d, dir_e, pw, m_dc, m_lc, m_vc, m_dd, m_ld, m_vd;
  logic [7:0] m_e, m_oc, m_nc, m_od, m_nd;
  logic e_we, hp_drv, pwm_en, pa, pb, pc, pd, act, ttl, m_act, act2;
  logic [1:0] mb;
  logic [7:0] dir_d2;
  dbp_pad_t pad_d2;
  logic [31:0] seed = 32'h0000004f;
  logic [31:0] r;
  int fail_count = 0;
  int checked = 0;
  always #10 clk = ~clk;
  // ==========================================================================
  // Design and pin partners
  dbp_top #(.HAS_BANK_D(1'b1)) i_dut (.clk(clk), .rst_n(rst_n), .wr_c(wr_c),
    .direction_bank_c(dir_c), .output_latch_bank_c(lat_c), .pin_bank_c_value(val_c),
    .ovr_c(ovr_c), .pin_c_in(pc_in), .pad_c(pad_c), .wr_d(wr_d),
    .direction_bank_d(dir_d), .output_latch_bank_d(lat_d), .pin_bank_d_value(val_d),
    .pin_d_in(pd_in), .pad_d(pad_d), .dir_e_we(e_we), .dir_e_wdata(e_wd),
    .direction_bank_e(dir_e), .host_parallel_data_port_drive(hp_drv),
    .host_parallel_data_port_out(hp_out), .host_parallel_data_port_active(act),
    .host_parallel_data_port_ttl(ttl), .enhanced_capture_pwm_unit_en(pwm_en),
    .pwm_mode(mode), .pwm_output_a(pa), .pwm_output_b(pb), .pwm_output_c(pc),
    .pwm_output_d(pd));
  // Variant without bank D, run on the same traffic
  dbp_top #(.HAS_BANK_D(1'b0)) i_dut_c_only (.clk(clk), .rst_n(rst_n), .wr_c(wr_c),
    .direction_bank_c(), .output_latch_bank_c(), .pin_bank_c_value(), .ovr_c(ovr_c),
    .pin_c_in(pc_in), .pad_c(), .wr_d(wr_d), .direction_bank_d(dir_d2),
    .output_latch_bank_d(), .pin_bank_d_value(), .pin_d_in(pd_in), .pad_d(pad_d2),
    .dir_e_we(e_we), .dir_e_wdata(e_wd), .direction_bank_e(),
    .host_parallel_data_port_drive(hp_drv), .host_parallel_data_port_out(hp_out),
    .host_parallel_data_port_active(act2), .host_parallel_data_port_ttl(),
    .enhanced_capture_pwm_unit_en(pwm_en), .pwm_mode(mode), .pwm_output_a(pa),
    .pwm_output_b(pb), .pwm_output_c(pc), .pwm_output_d(pd));
  dbp_pins i_pins_c (.pad(pad_c), .ext(ext_c), .pin_in(pc_in));
  dbp_pins i_pins_d (.pad(pad_d), .ext(ext_d), .pin_in(pd_in));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Reference model, compared just after every edge
  always @(posedge clk) begin
    m_vc = (m_nc & ext_c) | (~m_nc & m_oc);
    m_vd = (m_nd & ext_d) | (~m_nd & m_od);
    if (!rst_n) begin
      {m_dc, m_dd, m_nc, m_nd, m_lc, m_ld, m_oc, m_od} = {{4{8'hff}}, {4{8'h00}}};
      {m_vc, m_vd, m_e, m_act} = {8'h00, 8'h00, 8'h07, 1'b0};
    end else begin
      if (wr_c.dir_we) m_dc = wr_c.wdata;
      if (wr_c.lat_we | wr_c.port_we) m_lc = wr_c.wdata;
      if (wr_d.dir_we) m_dd = wr_d.wdata;
      if (wr_d.lat_we | wr_d.port_we) m_ld = wr_d.wdata;
      if (e_we) m_e = e_wd;
      m_act = m_e[4] && !(pwm_en && mode != DBP_PWM_SINGLE);
      m_nc = (ovr_c.ovr_en & ~ovr_c.ovr_out) | (~ovr_c.ovr_en & m_dc);
      m_oc = (ovr_c.ovr_en & ovr_c.ovr_val) | (~ovr_c.ovr_en & m_lc);
      m_nd = m_act ? {8{~hp_drv}} : m_dd;
      m_od = m_act ? hp_out : m_ld;
      pw = {{2{pwm_en & mode[1]}}, pwm_en & (mode != DBP_PWM_SINGLE), pwm_en, 4'h0};
      m_nd = m_nd & ~pw;
      m_od = (m_od & ~pw) | ({pd, pc, pb, pa, 4'h0} & pw);
    end
    #1;
    chk("dir_c", m_dc, dir_c);
    chk("lat_c", m_lc, lat_c);
    chk("val_c", m_vc, val_c);
    chk("oe_c", m_nc, pad_c.pin_oe_n);
    chk("out_c", m_oc & ~m_nc, pad_c.pin_out & ~pad_c.pin_oe_n);
    chk("dir_d", m_dd, dir_d);
    chk("lat_d", m_ld, lat_d);
    chk("val_d", m_vd, val_d);
    chk("oe_d", m_nd, pad_d.pin_oe_n);
    chk("out_d", m_od & ~m_nd, pad_d.pin_out & ~pad_d.pin_oe_n);
    chk("dir_e", m_e, dir_e);
    chk("active", {7'h00, m_act}, {7'h00, act});
    chk("ttl", {7'h00, m_act}, {7'h00, ttl});
    chk("dir_d_absent", DBP_DIR_RST, dir_d2);
    chk("oe_d_absent", DBP_DIR_RST, pad_d2.pin_oe_n);
    chk("active_absent", 8'h00, {7'h00, act2});
  end
  // ==========================================================================
  // Stimulus: random traffic in four regimes, with a reset mid-run
  initial begin
    {wr_c, wr_d, ovr_c, ext_c, ext_d, e_we, e_wd, hp_drv, hp_out} = '0;
    {pwm_en, pa, pb, pc, pd} = '0;
    mode = DBP_PWM_SINGLE;
    repeat (3) @(posedge clk);
    #2 rst_n = 1'b1;
    for (int i = 0; i < 1600; i++) begin
      @(posedge clk);
      #2;
      rst_n = !(i >= 800 && i < 803);
      r = xs();
      wr_c = {r[9:8] == 2'h0, r[11:10] == 2'h0, r[13:12] == 2'h0, r[7:0]};
      wr_d = {r[15:14] == 2'h0, r[17:16] == 2'h0, r[19:18] == 2'h0, r[31:24]};
      {e_we, hp_drv, pwm_en, mb, pa, pb, pc, pd} = {r[22:20] == 3'h0, r[23:16]};
      mode = dbp_pwm_mode_t'(mb);
      pwm_en = pwm_en & i[8];
      r = xs();
      ovr_c = {r[7:0] & {8{i[7]}}, r[31:16]};
      {ext_c, ext_d, hp_out} = {r[15:8], r[23:8]};
      e_wd = r[31:24];
    end
    report_and_stop();
  end
endmodule // testbench
